// *** verilog/afec_top.sv ***
// Auxiliary set/reset flip-flop and event counter with APB registers.
// Assumes function-bit inputs are asynchronous levels from drive pins.
`timescale 1ns/1ps
module afec_top import afec_pkg::*; #(
  parameter int COUNT_W = 32
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Function-bit inputs
  input  wire logic                  flipflop_clear_in,
  input  wire logic                  flipflop_set_in,
  input  wire logic                  count_pulse_in,
  input  wire logic                  count_clear_in,
  // Function-bit outputs
  output logic                       flipflop_out,
  output logic                       count_reached_out,
  // Interrupt
  output logic                       irq
);

  // ********************************************************************
  // Register decode
  // ********************************************************************
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    is_addr = (a == ref_a);
  endfunction : is_addr

  wire         acc      = psel & penable;
  wire         wr       = acc & pwrite;
  wire         hit_val  = is_addr(paddr, ADDR_COUNT_VALUE);
  wire         hit_tgt  = is_addr(paddr, ADDR_COUNT_TARGET);
  wire         hit_sts  = is_addr(paddr, ADDR_IRQ_STATUS);
  wire         hit_en   = is_addr(paddr, ADDR_IRQ_ENABLE);
  wire         hit_clr  = is_addr(paddr, ADDR_IRQ_CLEAR);
  wire         hit_pin  = is_addr(paddr, ADDR_PIN_STATUS);
  wire         hit_scan = is_addr(paddr, ADDR_SCAN_CTRL);
  wire         mapped   = hit_val | hit_tgt | hit_sts | hit_en | hit_clr | hit_pin | hit_scan;

  logic [COUNT_W-1:0]    count_q;
  logic [COUNT_W-1:0]    target_q;
  logic [31:0]           scan_q;
  logic [NUM_EVENTS-1:0] sts_q;
  logic [NUM_EVENTS-1:0] en_q;
  logic                  ff_q;
  logic                  reached_q;
  logic                  irq_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;

  // ********************************************************************
  // Input scanning
  // ********************************************************************
  // The scan period stands in for the software scan; inputs shorter than it may be missed.
  logic                  tick;
  logic [NUM_INPUTS-1:0] pins;
  logic [NUM_INPUTS-1:0] lvl;
  logic [NUM_INPUTS-1:0] rise;

  assign pins = {count_clear_in, count_pulse_in, flipflop_set_in, flipflop_clear_in};

  afec_scan_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .period  (scan_q),
    .tick    (tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
      afec_sync_edge u_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .sample_en (tick),
        .pin_in    (pins[gi]),
        .level_out (lvl[gi]),
        .rise_out  (rise[gi])
      );
    end
  endgenerate

  wire ff_clr_rise  = rise[0];
  wire ff_set_rise  = rise[1];
  wire cnt_rise     = rise[2];
  wire cnt_clr_rise = rise[3];

  // ********************************************************************
  // Flip-flop
  // ********************************************************************
  // Both edges in one tick: clear wins, the safer state for a drive.
  wire ff_d = ff_clr_rise ? 1'b0 : (ff_set_rise ? 1'b1 : ff_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_q <= 1'b0;
    end else begin
      ff_q <= ff_d;
    end
  end

  // ********************************************************************
  // Counter
  // ********************************************************************
  // The count saturates rather than wrapping so reached cannot fall silently.
  wire                count_max = &count_q;
  wire [COUNT_W-1:0]  count_d   = cnt_clr_rise ? '0 :
                                  (cnt_rise && !count_max) ? count_q + 1'b1 :
                                  count_q;
  wire                reached_d = (count_d >= target_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q   <= '0;
      reached_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      reached_q <= reached_d;
    end
  end

  // ********************************************************************
  // Interrupts
  // ********************************************************************
  logic [NUM_EVENTS-1:0] ev;
  assign ev[EV_FF_SET]      = ff_set_rise;
  assign ev[EV_FF_CLEAR]    = ff_clr_rise;
  assign ev[EV_REACHED]     = reached_d & ~reached_q;
  assign ev[EV_COUNT_CLEAR] = cnt_clr_rise;

  wire [NUM_EVENTS-1:0] clr_mask = (wr && hit_clr) ? pwdata[NUM_EVENTS-1:0] : '0;
  wire [NUM_EVENTS-1:0] sts_d    = (sts_q & ~clr_mask) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= '0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & en_q);
    end
  end

  // ********************************************************************
  // Register writes
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_q <= COUNT_W'(TARGET_RESET);
      en_q     <= '0;
      scan_q   <= SCAN_DIV_RESET;
    end else if (wr) begin
      if (hit_tgt) begin
        target_q <= pwdata[COUNT_W-1:0];
      end
      if (hit_en) begin
        en_q <= pwdata[NUM_EVENTS-1:0];
      end
      if (hit_scan) begin
        scan_q <= pwdata;
      end
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  wire [31:0] rd_mux = hit_val  ? 32'(count_q) :
                       hit_tgt  ? 32'(target_q) :
                       hit_sts  ? 32'(sts_q) :
                       hit_en   ? 32'(en_q) :
                       hit_pin  ? 32'({count_reached_out, flipflop_out, lvl}) :
                       hit_scan ? scan_q :
                       32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~is_addr(paddr, paddr & 8'hFC) | (psel & ~penable & ~mapped);
      prdata_q  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign flipflop_out      = ff_q;
  assign count_reached_out = reached_q;
  assign irq               = irq_q;
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;

endmodule : afec_top

// *** verilog/afec_pkg.sv ***
// Package for the auxiliary flip-flop and event counter block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package afec_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0]  ADDR_COUNT_VALUE  = 8'h00;
  localparam logic [7:0]  ADDR_COUNT_TARGET = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_CLEAR    = 8'h10;
  localparam logic [7:0]  ADDR_PIN_STATUS   = 8'h14;
  localparam logic [7:0]  ADDR_SCAN_CTRL    = 8'h18;

  localparam logic [31:0] TARGET_RESET      = 32'h0000_0000;
  localparam logic [31:0] SCAN_DIV_RESET    = 32'h0000_9C3F;

  // ********************************************************************
  // Event bits
  // ********************************************************************
  localparam int          NUM_EVENTS        = 4;
  localparam int          EV_FF_SET         = 0;
  localparam int          EV_FF_CLEAR       = 1;
  localparam int          EV_REACHED        = 2;
  localparam int          EV_COUNT_CLEAR    = 3;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int          CLK_HZ            = 40_000_000;
  localparam int          MIN_PULSE_US      = 2000;
  localparam int          MIN_PULSE_CYCLES  = MIN_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int          NUM_INPUTS        = 4;

endpackage : afec_pkg

// *** verilog/afec_sync_edge.sv ***
// Two-flop synchroniser with rising edge detection on a sampling enable.
// Assumes the input is an asynchronous pin level.
`timescale 1ns/1ps
module afec_sync_edge import afec_pkg::*; (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Sampling
  input  wire logic sample_en,
  input  wire logic pin_in,
  // Result
  output logic      level_out,
  output logic      rise_out
);

  logic meta_q;
  logic sync_q;
  logic level_q;
  logic rise_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // Sampling only on the scan tick catches a glitch shorter than a scan period only if it is present at a tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      rise_q <= sample_en & sync_q & ~level_q;
      if (sample_en) begin
        level_q <= sync_q;
      end
    end
  end

  assign level_out = level_q;
  assign rise_out  = rise_q;

endmodule : afec_sync_edge

// *** verilog/afec_scan_div.sv ***
// Divider producing a one-cycle scan tick from pclk.
// Assumes the period register is written by software at any time.
`timescale 1ns/1ps
module afec_scan_div import afec_pkg::*; (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic [31:0] period,
  // Tick
  output logic             tick
);

  logic [31:0] cnt_q;
  logic        tick_q;
  wire         wrap = (cnt_q >= period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
      tick_q <= wrap;
    end
  end

  assign tick = tick_q;

endmodule : afec_scan_div

// *** test/afec_fn_model.sv ***
// Model of the pin mapping logic that drives the four function bits.
// Assumes one-cycle requests from the bench, spaced apart.
`timescale 1ns/1ps
module afec_fn_model #(
  parameter int W = 6
) (
  // Clock
  input  wire logic       pclk,
  // Requests
  input  wire logic [3:0] req,
  // Pins
  output logic      [3:0] pins
);
  int left [4];
  initial pins = 4'h0;
  // Pulses outlast the scan period; shorter ones could slip between scans.
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (req[i]) left[i] = W;
      else if (left[i] > 0) left[i] = left[i] - 1;
      pins[i] <= left[i] > 0;
    end
  end
endmodule : afec_fn_model

// *** test/afec_top_properties.sv ***
// Checker on the ports of afec_top.
// Assumes a scan period of zero before any pin activity.
`timescale 1ns/1ps
module afec_chk import afec_pkg::*; (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        flipflop_clear_in,
  input wire logic        flipflop_set_in,
  input wire logic        count_pulse_in,
  input wire logic        count_clear_in,
  input wire logic        flipflop_out,
  input wire logic        count_reached_out
);
  logic [3:0] set_q, clr_q, cnt_q, zap_q;
  wire tw = psel && penable && pready && pwrite && paddr == ADDR_COUNT_TARGET;
  function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
    return hit ? 4'h0 : (a == 4'hF ? a : a + 4'h1);
  endfunction : age
  // Ages saturate, so a stale cause never excuses a late output change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_q <= 4'h0;
      clr_q <= 4'h0;
      cnt_q <= 4'h0;
      zap_q <= 4'h0;
    end else begin
      set_q <= age(flipflop_set_in, set_q);
      clr_q <= age(flipflop_clear_in, clr_q);
      cnt_q <= age(count_pulse_in, cnt_q);
      zap_q <= age(count_clear_in || tw, zap_q);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("long pready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata");
  a_err_unmapped: assert property (pready && paddr > ADDR_SCAN_CTRL |-> pslverr)
    else $error("no pslverr");
  a_ff_rise_set: assert property ($rose(flipflop_out) |-> set_q < 4'h8)
    else $error("ff rose alone");
  a_ff_fall_clear: assert property ($fell(flipflop_out) |-> clr_q < 4'h8)
    else $error("ff fell alone");
  a_reach_rise_cause: assert property ($rose(count_reached_out) |-> cnt_q < 4'h8 || zap_q < 4'h8)
    else $error("reached rose alone");
  a_reach_fall_cause: assert property ($fell(count_reached_out) |-> zap_q < 4'h8)
    else $error("reached fell alone");
  c_ff: cover property ($rose(flipflop_out));
  c_reach: cover property ($rose(count_reached_out));
  c_err: cover property (pslverr);
endmodule : afec_chk
bind afec_top afec_chk afec_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flipflop_clear_in(flipflop_clear_in),
  .flipflop_set_in(flipflop_set_in), .count_pulse_in(count_pulse_in),
  .count_clear_in(count_clear_in), .flipflop_out(flipflop_out),
  .count_reached_out(count_reached_out));

// *** test/afec_tb_top.sv ***
// Bench for afec_top: APB master, pin model and integer score model.
// Assumes the scan period register may be set to zero.
`timescale 1ns/1ps
module afec_tb_top import afec_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, flipflop_out, count_reached_out, irq, err, ff = 1'b0, rp;
  logic [3:0] req = 4'h0, pins, ev;
  int bad_count = 0, checks = 0, cyc = 0, cnt = 0, tgt = 0;
  always #12.5 pclk = ~pclk;
  afec_fn_model #(.W(6)) afec_fn_model_i (.pclk(pclk), .req(req), .pins(pins));
  afec_top afec_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flipflop_clear_in(pins[0]), .flipflop_set_in(pins[1]),
    .count_pulse_in(pins[2]), .count_clear_in(pins[3]), .flipflop_out(flipflop_out),
    .count_reached_out(count_reached_out), .irq(irq));
  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      wrap_up;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  function automatic void upd();
    if (cnt >= tgt && !rp) ev[EV_REACHED] = 1'b1;
    rp = cnt >= tgt;
  endfunction : upd
  task automatic pulse(input int i);
    @(posedge pclk);
    req[i] <= 1'b1;
    @(posedge pclk);
    req[i] <= 1'b0;
    repeat (18) @(posedge pclk);
    if (i == 0) ff = 1'b0;
    if (i == 1) ff = 1'b1;
    if (i == 2) cnt++;
    if (i == 3) cnt = 0;
    ev[i == 0 ? EV_FF_CLEAR : i == 1 ? EV_FF_SET : i == 3 ? EV_COUNT_CLEAR : EV_REACHED]
      |= i != 2;
    upd();
    chk("ff", ff, flipflop_out);
    chk("reached", rp, count_reached_out);
  endtask : pulse
  initial begin
    void'($urandom(32'h400E));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("reached", 1'b1, count_reached_out);
    rdc(ADDR_COUNT_TARGET, TARGET_RESET, "target");
    rdc(ADDR_SCAN_CTRL, SCAN_DIV_RESET, "scan");
    apb(1'b1, ADDR_SCAN_CTRL, 32'h0);
    apb(1'b1, ADDR_IRQ_CLEAR, 32'hF);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'hF);
    ev = 4'h0;
    rp = 1'b1;
    apb(1'b0, 8'h1C, 32'h0);
    chk("pslverr", 1'b1, err);
    chk("unmapped", 32'h0, rd);
    for (int k = 0; k < 2; k++) begin
      tgt = $urandom % 4 + 1;
      apb(1'b1, ADDR_COUNT_TARGET, 32'(tgt));
      upd();
      rdc(ADDR_COUNT_TARGET, 32'(tgt), "target");
      pulse(3);
      for (int j = 0; j <= tgt + 1; j++) begin
        pulse(2);
        rdc(ADDR_COUNT_VALUE, 32'(cnt), "count");
      end
    end
    apb(1'b1, ADDR_COUNT_VALUE, 32'h0);
    rdc(ADDR_COUNT_VALUE, 32'(cnt), "count ro");
    pulse(3);
    rdc(ADDR_COUNT_VALUE, 32'h0, "count");
    for (int i = 1; i < 5; i++) pulse(i / 3);
    rdc(ADDR_IRQ_STATUS, 32'(ev), "status");
    chk("irq", 1'b1, irq);
    apb(1'b1, ADDR_IRQ_CLEAR, 32'hF);
    rdc(ADDR_IRQ_STATUS, 32'h0, "status");
    chk("irq", 1'b0, irq);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
    pulse(0);
    chk("irq", 1'b0, irq);
    pulse(1);
    chk("irq", 1'b1, irq);
    rdc(ADDR_IRQ_ENABLE, 32'h0000_0001, "enable");
    rdc(ADDR_PIN_STATUS, 32'({rp, ff, 4'h0}), "pin status");
    wrap_up;
  end
endmodule : afec_tb_top
